// File: fch_top.sv
// Behaviour
// R1: Master issues speed command, then stop position, then start command.
// R2: Position-feed active flag is raised; master checks it before sequencing.
// R3: Speed-feed active flag is raised; master checks it before sequencing.
// R4: Master puts the speed command into the speed-command word.
// R5: Speed command counts hundredths of a hertz; 6000 means 60 Hz.
// R6: Frequency write request copies speed command into working memory.
// R7: Frequency write complete flag raised after the write is taken.
// R8: Reply code word reports result; zero means success.
// R9: Master writes stop target, tenths of millimetre, as lower and upper word.
// R10: Stop target is a plain count of tenths of millimetre.
// R11: Stop write request makes the device take the new target.
// R12: Stop receipt complete flag raised when a stop write is taken.
// R13: Not-applied flag raised when a written target is rejected.
// R14: Accepted stop target echoed in lower and upper monitor words.
// R15: Master requests motion with forward or reverse start bit.
// R16: Position feed start opens brake and moves toward accepted target.
// R17: Speed feed start opens brake and accelerates to commanded frequency.
// R18: Start released: decelerate to stop, then drop brake request.
// R19: Ramps use the configured acceleration and deceleration pattern.
// R20: Stop target is signed 32 bits, low half and high half words.
// R21: Target outside configured motion range is not applied, flag raised.
// R22: Master holds each request until its completion flag, then releases.
`timescale 1ns/10ps
module fch_top
  import fch_pkg::*;
#(
  parameter int RAMP_TICK_CYCLES = FCH_RAMP_TICK_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             brake_open_request_o,
  output logic             reverse_dir_o,
  output logic [15:0]      run_freq_o
);

  // Software-written state
  logic [31:0] ctrl;
  logic [15:0] speed_cmd;
  logic [31:0] stop_wr;
  logic [31:0] range_min;
  logic [31:0] range_max;
  logic [31:0] ramp_cfg;
  logic [15:0] freq_lim;
  // Device state
  logic [15:0] work_freq;
  logic        freq_done;
  logic [15:0] reply_code;
  logic        stop_done;
  logic        stop_na;
  logic [31:0] stop_target;
  logic        pos_active;
  logic        spd_active;
  logic [31:0] cur_pos;
  fch_state_t  state;
  logic        pos_mode_run;
  logic [31:0] tick_cnt;
  logic        tick;
  // Bus capture
  logic [7:0]  aw_addr;
  logic        aw_full;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_full;
  logic        do_write;
  logic        wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic start_req;
  logic at_target;
  logic [15:0] acc_step;
  logic [15:0] dec_step;
  assign start_req = ctrl[FCH_CTRL_FWD] | ctrl[FCH_CTRL_REV];
  assign at_target = (cur_pos == stop_target);
  assign acc_step  = ramp_cfg[15:0];
  assign dec_step  = ramp_cfg[31:16];
  assign do_write  = aw_full & w_full & ~s_axi_bvalid_o;
  // Only aligned words below the status block take writes
  assign wr_hit    = (aw_addr < FCH_STATUS_OFF) && (aw_addr[1:0] == 2'b00);

  // Byte-lane merge of a write onto an old word
  function automatic logic [31:0] fch_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    for (int b = 0; b < 4; b++) begin
      res[8*b +: 8] = strb[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    end
    return res;
  endfunction : fch_merge

  // Address and data channels are taken independently, in either order
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      aw_full         <= 1'b0;
      aw_addr         <= 8'h00;
      s_axi_awready_o <= 1'b0;
      w_full          <= 1'b0;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_wready_o  <= 1'b0;
    end else if (clk_en_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full         <= 1'b1;
        aw_addr         <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end else if (!aw_full && !s_axi_bvalid_o) begin
        s_axi_awready_o <= 1'b1;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full         <= 1'b1;
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end else if (do_write) begin
        w_full <= 1'b0;
      end else if (!w_full && !s_axi_bvalid_o) begin
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Write response; status words and holes answer SLVERR
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= FCH_RESP_OKAY;
    end else if (clk_en_i) begin
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? FCH_RESP_OKAY : FCH_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Software registers; stop target is two 16-bit halves of one word
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctrl      <= 32'h0000_0000;
      speed_cmd <= 16'h0000;
      stop_wr   <= 32'h0000_0000;
      range_min <= FCH_RANGE_MIN_RST;
      range_max <= FCH_RANGE_MAX_RST;
      ramp_cfg  <= FCH_RAMP_RST;
      freq_lim  <= FCH_FREQ_LIM_RST;
    end else if (clk_en_i && do_write) begin
      case (aw_addr)
        FCH_CTRL_OFF:      ctrl      <= fch_merge(ctrl, w_data, w_strb);
        FCH_SPEED_CMD_OFF: speed_cmd <= 16'(fch_merge({16'h0000, speed_cmd},
                                          w_data, w_strb)); // R5
        FCH_STOP_LO_OFF:   stop_wr[15:0]  <= 16'(fch_merge({16'h0000,
                             stop_wr[15:0]}, w_data, w_strb)); // R20
        FCH_STOP_HI_OFF:   stop_wr[31:16] <= 16'(fch_merge({16'h0000,
                             stop_wr[31:16]}, w_data, w_strb)); // R20
        FCH_RANGE_MIN_OFF: range_min <= fch_merge(range_min, w_data, w_strb);
        FCH_RANGE_MAX_OFF: range_max <= fch_merge(range_max, w_data, w_strb);
        FCH_RAMP_OFF:      ramp_cfg  <= fch_merge(ramp_cfg, w_data, w_strb);
        FCH_FREQ_LIM_OFF:  freq_lim  <= 16'(fch_merge({16'h0000, freq_lim},
                                          w_data, w_strb));
        default: ;
      endcase
    end
  end

  // Read mux; upper bits of narrow words read as zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_i)
      FCH_CTRL_OFF:      rd_word = ctrl;
      FCH_SPEED_CMD_OFF: rd_word = {16'h0000, speed_cmd};
      FCH_STOP_LO_OFF:   rd_word = {16'h0000, stop_wr[15:0]};
      FCH_STOP_HI_OFF:   rd_word = {16'h0000, stop_wr[31:16]};
      FCH_RANGE_MIN_OFF: rd_word = range_min;
      FCH_RANGE_MAX_OFF: rd_word = range_max;
      FCH_RAMP_OFF:      rd_word = ramp_cfg;
      FCH_FREQ_LIM_OFF:  rd_word = {16'h0000, freq_lim};
      FCH_STATUS_OFF:    rd_word = {25'h0000000, state != FCH_IDLE,
                          brake_open_request_o, stop_na, stop_done,
                          freq_done, spd_active, pos_active};
      FCH_REPLY_OFF:     rd_word = {16'h0000, reply_code}; // R8
      FCH_STOP_MLO_OFF:  rd_word = {16'h0000, stop_target[15:0]}; // R14
      FCH_STOP_MHI_OFF:  rd_word = {16'h0000, stop_target[31:16]}; // R14
      FCH_RUN_FREQ_OFF:  rd_word = {16'h0000, run_freq_o};
      FCH_CUR_POS_OFF:   rd_word = cur_pos;
      default:           rd_hit  = 1'b0;
    endcase
  end

  // Read channel: one read at a time, answer the cycle after the take
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= FCH_RESP_OKAY;
    end else if (clk_en_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_word;
        s_axi_rresp_o   <= rd_hit ? FCH_RESP_OKAY : FCH_RESP_SLVERR;
      end else if (s_axi_rvalid_o) begin
        s_axi_rvalid_o <= ~s_axi_rready_i;
      end else begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Mode flags follow the selected feed operation
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pos_active <= 1'b0;
      spd_active <= 1'b0;
    end else if (clk_en_i) begin
      pos_active <= ctrl[FCH_CTRL_POSM]; // R2
      spd_active <= ~ctrl[FCH_CTRL_POSM]; // R3
    end
  end

  // Frequency write: level request, done flag held until request drops
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      work_freq  <= 16'h0000;
      freq_done  <= 1'b0;
      reply_code <= FCH_REPLY_OK;
    end else if (clk_en_i) begin
      if (ctrl[FCH_CTRL_FREQW] && !freq_done) begin
        freq_done <= 1'b1; // R7
        if (speed_cmd <= freq_lim) begin
          work_freq  <= speed_cmd; // R6
          reply_code <= FCH_REPLY_OK; // R8
        end else begin
          reply_code <= FCH_REPLY_RANGE; // R8
        end
      end else if (!ctrl[FCH_CTRL_FREQW]) begin
        freq_done <= 1'b0;
      end
    end
  end

  // Signed range check; a rejected target leaves the old one in force
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      stop_target <= 32'h0000_0000;
      stop_done   <= 1'b0;
      stop_na     <= 1'b0;
    end else if (clk_en_i) begin
      if (ctrl[FCH_CTRL_STOPW] && !stop_done) begin
        stop_done <= 1'b1; // R12
        if ($signed(stop_wr) >= $signed(range_min) &&
            $signed(stop_wr) <= $signed(range_max)) begin
          stop_target <= stop_wr; // R11 R10
          stop_na     <= 1'b0;
        end else begin
          stop_na <= 1'b1; // R13 R21
        end
      end else if (!ctrl[FCH_CTRL_STOPW]) begin
        stop_done <= 1'b0;
      end
    end
  end

  // Ramp tick divider; long period so it is a parameter
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (clk_en_i) begin
      if (tick_cnt >= 32'(RAMP_TICK_CYCLES - 1)) begin
        tick_cnt <= 32'h0000_0000;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
        tick     <= 1'b0;
      end
    end
  end

  // Motion sequencer: brake opens on start, closes only at zero speed
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state                <= FCH_IDLE;
      brake_open_request_o <= 1'b0;
      reverse_dir_o        <= 1'b0;
      run_freq_o           <= 16'h0000;
      pos_mode_run         <= 1'b0;
    end else if (clk_en_i) begin
      case (state)
        FCH_IDLE: begin
          if (start_req) begin
            state                <= FCH_RUN;
            brake_open_request_o <= 1'b1; // R16 R17
            reverse_dir_o        <= ~ctrl[FCH_CTRL_FWD];
            pos_mode_run         <= pos_active;
          end
        end
        FCH_RUN: begin
          if (!start_req || (pos_mode_run && at_target)) begin
            state <= FCH_STOP; // R18
          end else if (tick) begin
            // Saturating ramp toward the working frequency
            if (run_freq_o < work_freq) begin
              run_freq_o <= (work_freq - run_freq_o > acc_step) ?
                            run_freq_o + acc_step : work_freq; // R19 R17
            end else if (run_freq_o > work_freq) begin
              run_freq_o <= (run_freq_o - work_freq > dec_step) ?
                            run_freq_o - dec_step : work_freq; // R19
            end
          end
        end
        FCH_STOP: begin
          if (run_freq_o == 16'h0000) begin
            state                <= FCH_IDLE;
            brake_open_request_o <= 1'b0; // R18
          end else if (tick) begin
            run_freq_o <= (run_freq_o > dec_step) ?
                          run_freq_o - dec_step : 16'h0000; // R18 R19
          end
        end
        default: begin
          state                <= FCH_IDLE;
          brake_open_request_o <= 1'b0;
        end
      endcase
    end
  end

  // Coarse position model: one count per tick while turning in position feed
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cur_pos <= 32'h0000_0000;
    end else if (clk_en_i && tick && pos_mode_run &&
                 state != FCH_IDLE && run_freq_o != 16'h0000) begin
      if ($signed(cur_pos) < $signed(stop_target)) begin
        cur_pos <= cur_pos + 32'h0000_0001; // R16
      end else if ($signed(cur_pos) > $signed(stop_target)) begin
        cur_pos <= cur_pos - 32'h0000_0001; // R16
      end
    end
  end

endmodule : fch_top

// File: fch_pkg.sv
package fch_pkg;
  // Byte offsets of the register words
  localparam logic [7:0] FCH_CTRL_OFF       = 8'h00;
  localparam logic [7:0] FCH_SPEED_CMD_OFF  = 8'h04;
  localparam logic [7:0] FCH_STOP_LO_OFF    = 8'h08;
  localparam logic [7:0] FCH_STOP_HI_OFF    = 8'h0C;
  localparam logic [7:0] FCH_RANGE_MIN_OFF  = 8'h10;
  localparam logic [7:0] FCH_RANGE_MAX_OFF  = 8'h14;
  localparam logic [7:0] FCH_RAMP_OFF       = 8'h18;
  localparam logic [7:0] FCH_FREQ_LIM_OFF   = 8'h1C;
  localparam logic [7:0] FCH_STATUS_OFF     = 8'h20;
  localparam logic [7:0] FCH_REPLY_OFF      = 8'h24;
  localparam logic [7:0] FCH_STOP_MLO_OFF   = 8'h28;
  localparam logic [7:0] FCH_STOP_MHI_OFF   = 8'h2C;
  localparam logic [7:0] FCH_RUN_FREQ_OFF   = 8'h30;
  localparam logic [7:0] FCH_CUR_POS_OFF    = 8'h34;

  // Control word bit positions
  localparam int FCH_CTRL_FWD   = 0;
  localparam int FCH_CTRL_REV   = 1;
  localparam int FCH_CTRL_FREQW = 2;
  localparam int FCH_CTRL_STOPW = 3;
  localparam int FCH_CTRL_POSM  = 4;

  // Status word bit positions
  localparam int FCH_ST_POS_ACT  = 0;
  localparam int FCH_ST_SPD_ACT  = 1;
  localparam int FCH_ST_FREQ_OK  = 2;
  localparam int FCH_ST_STOP_OK  = 3;
  localparam int FCH_ST_STOP_NA  = 4;
  localparam int FCH_ST_BRAKE    = 5;
  localparam int FCH_ST_MOVING   = 6;

  // Reset values
  localparam logic [31:0] FCH_RANGE_MIN_RST = 32'h8000_0000;
  localparam logic [31:0] FCH_RANGE_MAX_RST = 32'h7FFF_FFFF;
  localparam logic [31:0] FCH_RAMP_RST      = 32'h0001_0001;
  localparam logic [15:0] FCH_FREQ_LIM_RST  = 16'hFFFF;

  // Reply codes
  localparam logic [15:0] FCH_REPLY_OK      = 16'h0000;
  localparam logic [15:0] FCH_REPLY_RANGE   = 16'h0003;

  // AXI responses
  localparam logic [1:0] FCH_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FCH_RESP_SLVERR = 2'h2;

  // Ramp tick: one step of the frequency ramp
  localparam int FCH_CLK_MHZ      = 40;
  localparam int FCH_RAMP_TICK_US = 1000;
  localparam int FCH_RAMP_TICK_CYC = FCH_RAMP_TICK_US * FCH_CLK_MHZ;

  typedef enum logic [1:0] {
    FCH_IDLE = 2'b00,
    FCH_RUN  = 2'b01,
    FCH_STOP = 2'b10
  } fch_state_t;
endpackage : fch_pkg

// File: fch_assertions.sv
`timescale 1ns/10ps
// Watches the register bus and the brake output of the drive
module fch_assertions (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        brake_open_request_o,
  input wire logic [15:0] run_freq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Address and data of a write taken at the same edge
  sequence s_wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  // Bus answers; a late ready must not lose the answer
  chk_write_answer: assert property (
    s_wr_both |-> ##2 s_axi_bvalid_o) else $error("write answer late");
  chk_bresp_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write answer dropped");
  chk_ready_return: assert property (
    $fell(s_axi_bvalid_o) |=> s_axi_awready_o && s_axi_wready_o)
    else $error("write readies not back");
  chk_read_answer: assert property (
    s_rd_take |=> s_axi_rvalid_o) else $error("read answer late");
  chk_rdata_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read answer changed");
  chk_read_busy: assert property (
    s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken twice");

  // Brake only released at standstill
  chk_brake_idle: assert property (
    !brake_open_request_o |-> run_freq_o == 16'h0000)
    else $error("motor runs with brake closed");
  chk_brake_drop: assert property (
    $fell(brake_open_request_o) |-> $past(run_freq_o) == 16'h0000)
    else $error("brake closed before stop");
  chk_start_rest: assert property (
    $rose(brake_open_request_o) |-> run_freq_o == 16'h0000)
    else $error("start not from rest");
endmodule : fch_assertions

// File: fch_master.sv
`timescale 1ns/10ps
// Fieldbus controller model speaking the drive's register bus
module fch_master (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  // Idle bus at time zero
  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = 52'h0;
  end

  // One write; ready for the answer only after lag cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input int lag, output logic [1:0] r, output bit to);
    int n;
    n = 0;
    @(posedge clk_i);
    {awaddr_o, wdata_o, wstrb_o} <= {a, d, 4'hF};
    {awvalid_o, wvalid_o} <= 2'b11;
    do begin
      @(posedge clk_i);
      n++;
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a; // Released address and data lines never keep the old value
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~d;
      end
      if (n >= lag && !bready_o) bready_o <= 1'b1;
    end while (!(bready_o && bvalid_i) && n < 64);
    r  = bresp_i;
    to = (n >= 64);
    bready_o <= 1'b0;
  endtask : wr

  // One read; same slow-answer option
  task automatic rd(input logic [7:0] a, input int lag,
                    output logic [31:0] d, output logic [1:0] r,
                    output bit to);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
      end
      if (n >= lag && !rready_o) rready_o <= 1'b1;
    end while (!(rready_o && rvalid_i) && n < 64);
    {d, r} = {rdata_i, rresp_i};
    to = (n >= 64);
    rready_o <= 1'b0;
  endtask : rd
endmodule : fch_master

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import fch_pkg::*;
  localparam int         TICK = 4;
  localparam logic [1:0] OK   = FCH_RESP_OKAY;
  localparam logic [1:0] SE   = FCH_RESP_SLVERR;
  typedef struct {
    logic [7:0] a; logic [31:0] wd; logic [1:0] wr;
    logic [31:0] rd; logic [1:0] rr;
  } fch_row_t;
  logic        core_clk_i, reset_n_i, brake_open_request_o, reverse_dir_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic        s_axi_rready_i, clk_en_i;
  logic [15:0] run_freq_o, frz;
  int          err_count, n_checks, slow;
  fch_row_t    rows [7];

  fch_top #(.RAMP_TICK_CYCLES(TICK)) DUT (.core_clk_i, .reset_n_i,
    .clk_en_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .brake_open_request_o,
    .reverse_dir_o, .run_freq_o);
  fch_master u_mst (.clk_i(core_clk_i), .awaddr_o(s_axi_awaddr_i),
    .awvalid_o(s_axi_awvalid_i), .awready_i(s_axi_awready_o),
    .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o),
    .bresp_i(s_axi_bresp_o), .bvalid_i(s_axi_bvalid_o),
    .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o),
    .rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o),
    .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));

  // 40 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Counting, comparing and the verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic fail(input string m);
    err_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : fail
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) fail($sformatf("data %h exp %h", g, e));
  endtask : chk32
  task automatic chkresp(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e) fail($sformatf("resp %h exp %h", g, e));
  endtask : chkresp
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) fail($sformatf("flag %b exp %b", g, e));
  endtask : chk1

  // Bus access with response check; a hung bus ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    bit         to;
    u_mst.wr(a, d, slow, r, to);
    if (to) begin
      fail("write hung");
      final_report();
    end
    chkresp(r, er);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [1:0] er,
                    input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    bit          to;
    u_mst.rd(a, slow, d, r, to);
    if (to) begin
      fail("read hung");
      final_report();
    end
    chkresp(r, er);
    chk32(d & m, e);
  endtask : rc
  // Bounded wait for a brake and frequency state
  task automatic wait_out(input logic b, input logic [15:0] f);
    int n;
    n = 0;
    while (n < 600 && !(brake_open_request_o === b && run_freq_o === f)) begin
      @(posedge core_clk_i);
      n++;
    end
    chk1(n < 600, 1'b1);
    if (n >= 600) final_report();
  endtask : wait_out

  // Main sequence: table first, then reset, speed-feed and position-feed cases
  initial begin
    reset_n_i = 1'b0;
    clk_en_i  = 1'b1;
    {err_count, n_checks, slow} = '0;
    rows = '{'{FCH_SPEED_CMD_OFF, 32'h1770, OK, 32'h1770, OK},
             '{FCH_STOP_LO_OFF, 32'hFFFF86A0, OK, 32'h86A0, OK},
             '{FCH_STOP_HI_OFF, 32'h1, OK, 32'h1, OK},
             '{FCH_RANGE_MAX_OFF, 32'h186A0, OK, 32'h186A0, OK},
             '{FCH_RAMP_OFF, 32'h50005, OK, 32'h50005, OK},
             '{8'h40, 32'h1, SE, 32'h0, SE},
             '{FCH_STOP_MLO_OFF, 32'h5, SE, 32'h0, OK}};
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd, rows[i].wr);
      rc(rows[i].a, rows[i].rr, 32'hFFFFFFFF, rows[i].rd);
    end
    // Mid-run reset, read back slowly
    @(posedge core_clk_i) reset_n_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    slow = 3;
    rc(FCH_RANGE_MAX_OFF, OK, 32'hFFFFFFFF, FCH_RANGE_MAX_RST);
    rc(FCH_RAMP_OFF, OK, 32'hFFFFFFFF, FCH_RAMP_RST);
    rc(FCH_STATUS_OFF, OK, 32'h3, 32'h2);
    // Speed feed: command, write request, start both ways, stop
    wr(FCH_RAMP_OFF, 32'h50005, OK);
    slow = 0;
    wr(FCH_SPEED_CMD_OFF, 32'd20, OK);
    wr(FCH_CTRL_OFF, 32'h4, OK);
    rc(FCH_STATUS_OFF, OK, 32'h4, 32'h4);
    rc(FCH_REPLY_OFF, OK, 32'hFFFF, 32'h0);
    wr(FCH_CTRL_OFF, 32'h0, OK);
    rc(FCH_STATUS_OFF, OK, 32'h4, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(FCH_CTRL_OFF, 32'h1 << k, OK);
      wait_out(1'b1, 16'd20);
      chk1(reverse_dir_o, k[0]);
      wr(FCH_CTRL_OFF, 32'h0, OK);
      wait_out(1'b0, 16'd0);
    end
    // Enable low freezes the ramp part-way up
    wr(FCH_CTRL_OFF, 32'h1, OK);
    repeat (6) @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    frz = run_freq_o;
    repeat (20) @(posedge core_clk_i);
    chk1(run_freq_o == frz && frz inside {[16'd1:16'd19]}, 1'b1);
    clk_en_i <= 1'b1;
    wr(FCH_CTRL_OFF, 32'h0, OK);
    wait_out(1'b0, 16'd0);
    // Speed above the limit is refused with a nonzero reply
    wr(FCH_FREQ_LIM_OFF, 32'd10, OK);
    wr(FCH_SPEED_CMD_OFF, 32'd50, OK);
    wr(FCH_CTRL_OFF, 32'h4, OK);
    rc(FCH_REPLY_OFF, OK, 32'hFFFF, {16'h0, FCH_REPLY_RANGE});
    // Position feed: rejected target, accepted target, run to it
    wr(FCH_CTRL_OFF, 32'h10, OK);
    rc(FCH_STATUS_OFF, OK, 32'h3, 32'h1);
    wr(FCH_RANGE_MAX_OFF, 32'd100, OK);
    wr(FCH_STOP_LO_OFF, 32'd200, OK);
    wr(FCH_STOP_HI_OFF, 32'd0, OK);
    wr(FCH_CTRL_OFF, 32'h18, OK);
    rc(FCH_STATUS_OFF, OK, 32'h18, 32'h18);
    rc(FCH_STOP_MLO_OFF, OK, 32'hFFFF, 32'h0);
    wr(FCH_CTRL_OFF, 32'h10, OK);
    wr(FCH_STOP_LO_OFF, 32'd10, OK);
    wr(FCH_CTRL_OFF, 32'h18, OK);
    rc(FCH_STATUS_OFF, OK, 32'h18, 32'h08);
    rc(FCH_STOP_MLO_OFF, OK, 32'hFFFF, 32'd10);
    wr(FCH_CTRL_OFF, 32'h10, OK);
    wr(FCH_CTRL_OFF, 32'h11, OK);
    wait_out(1'b1, 16'd0);
    wait_out(1'b0, 16'd0);
    rc(FCH_CUR_POS_OFF, OK, 32'hFFFFFFFF, 32'd10);
    final_report();
  end
endmodule : tb_top

bind fch_top fch_assertions u_chk (.core_clk_i, .reset_n_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .brake_open_request_o,
  .run_freq_o);
